// ===== serial_adc_frame_control_tb_top.sv
// Purpose: Host and device joined back to back, results checked
// Assumes: Conversion count cut to 20 cycles, gap 40 cycles
// Notes:   Wire bits captured on falling shift clock by the bench
`timescale 1ns/1ps
`include "sfc_defines.svh"
module serial_adc_frame_control_tb_top;
  localparam int HALF = 4;
  localparam int GAP  = 40;
  localparam int CONV = 20;
  logic        clk_in, nrst_in, start_in, init_in, use_fs_in;
  logic [15:0] analog_code_in, data_out, cap, last;
  logic        busy_out, done_out, sampling_out, converting_out;
  logic        init_seen_out;
  logic        sclk_q, sel_q, fs_q;
  int          n_errors, compares, ncap, ndone, samp_len, conv_len;
  // Kind: bit 1 init frame, bit 0 frame-sync framing
  logic [1:0]  kinds [11] = '{2'h2, 2'h0, 2'h0, 2'h1, 2'h3, 2'h1,
                              2'h1, 2'h0, 2'h0, 2'h0, 2'h1};
  logic [15:0] codes [11] = '{16'h0, 16'h8001, 16'h7ffe, 16'ha5a5,
                              16'h0, 16'h0000, 16'hffff, 16'h1234,
                              16'h0f0f, 16'h5555, 16'haaaa};
  sfc_link_if link();
  sfc_device #(.CONV_CYCLES(CONV)) u_sfc_device (
    .clk_in(clk_in), .nrst_in(nrst_in), .link(link),
    .analog_code_in(analog_code_in), .sampling_out(sampling_out),
    .converting_out(converting_out), .init_seen_out(init_seen_out));
  sfc_host #(.HALF(HALF), .GAP(GAP)) u_sfc_host (
    .clk_in(clk_in), .nrst_in(nrst_in), .link(link),
    .start_in(start_in), .init_in(init_in), .use_fs_in(use_fs_in),
    .busy_out(busy_out), .done_out(done_out), .data_out(data_out));
  sfc_link_monitor u_sfc_link_monitor (
    .clk_in(clk_in), .nrst_in(nrst_in), .sclk(link.sclk),
    .sel_n(link.sel_n), .frame_sync_input(link.frame_sync_input),
    .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe),
    .serial_result_out(link.serial_result_out));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Bounded wait at settled negedges; a hang ends the run
  task automatic wait_lv(ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    while (s !== v) begin
      @(negedge clk_in);
      k++;
      if (k > lim) begin
        n_errors++;
        $display("[ERR] %0t wait ran out", $time);
        tally_and_finish;
      end
    end
  endtask
  // Wire capture, sampling and conversion length watch
  always @(posedge clk_in) begin
    sclk_q <= link.sclk;
    sel_q  <= link.sel_n;
    fs_q   <= link.frame_sync_input;
    if ((sel_q && !link.sel_n) || (fs_q && !link.frame_sync_input))
      ncap <= 0;
    else if (sclk_q && !link.sclk && ncap < 16) begin
      cap  <= {cap[14:0], link.serial_result_out};
      ncap <= ncap + 1;
    end
    if (done_out === 1'b1)
      ndone <= ndone + 1;
    if (sampling_out === 1'b1)
      samp_len <= samp_len + 1;
    else if (samp_len != 0) begin
      check(16'(samp_len), 16'(2 * HALF * `SFC_SAMPLE_LEN));
      samp_len <= 0;
    end
    if (converting_out === 1'b1)
      conv_len <= conv_len + 1;
    else if (conv_len != 0) begin
      check(16'(conv_len), 16'(CONV));
      conv_len <= 0;
    end
  end
  // One frame; a stray start mid-frame must be ignored
  task automatic frame(input logic [1:0] k, input logic [15:0] code);
    int d0;
    @(posedge clk_in);
    analog_code_in <= code;
    use_fs_in      <= k[0];
    start_in       <= !k[1];
    init_in        <= k[1];
    d0 = ndone;
    @(posedge clk_in);
    start_in <= 1'b0;
    init_in  <= 1'b0;
    if (!k[1]) begin
      repeat (30) @(posedge clk_in);
      start_in <= 1'b1;
      @(posedge clk_in);
      start_in <= 1'b0;
      wait_lv(done_out, 1'b1, 600);
      check(data_out, last);
      check(cap, last);
      last = code;
    end else
      last = `SFC_RESET_CODE;
    // Let the host register the request before waiting for idle
    @(negedge clk_in);
    wait_lv(busy_out, 1'b0, 600);
    repeat (GAP) @(posedge clk_in);
    check(16'(ndone - d0), {15'h0, !k[1]});
    check({15'h0, init_seen_out}, {15'h0, k[1]});
  endtask
  initial begin
    nrst_in = 1'b0; start_in = 1'b0; init_in = 1'b0; use_fs_in = 1'b0;
    analog_code_in = 16'h0; cap = 16'h0; n_errors = 0; compares = 0;
    ncap = 0; ndone = 0; samp_len = 0; conv_len = 0;
    sclk_q = 1'b0; sel_q = 1'b1; fs_q = 1'b0;
    last = `SFC_RESET_CODE;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      if (i == 9) begin
        nrst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        last = `SFC_RESET_CODE;
      end
      frame(kinds[i], codes[i]);
    end
    tally_and_finish;
  end
endmodule

// ===== sfc_defines.svh
// Purpose: Shared timing counts and codes for the serial converter link
// Assumes: All counts in shift-clock edges or 200 MHz system clock cycles
// Notes:   Guarded; holds definitions only
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH
`define SFC_RESULT_W      16
`define SFC_RESET_CODE    16'hff00
`define SFC_INIT_MIN_EDGE 1
`define SFC_INIT_MAX_EDGE 8
`define SFC_SAMPLE_FIRST  5
`define SFC_SAMPLE_LEN    20
`define SFC_CONV_EDGE     24
`define SFC_TRISTATE_EDGE 17
`define SFC_READ_EDGES    16
`define SFC_OSC_CYCLES    22
`define SFC_CONV_TIME_NS  2940
`define SFC_CLK_PERIOD_NS 5
// Longest time rounds down to whole system cycles
`define SFC_CONV_CYCLES   (`SFC_CONV_TIME_NS / `SFC_CLK_PERIOD_NS)
`define SFC_SCLK_HALF     4
`endif

// ===== sfc_device.sv
// Purpose: Converter end: frame decode, result shifting, conversion timer
// Assumes: Link pins synchronous to clk_in; conversion value from a port
// Notes:   Oscillator time modelled as a system-clock count
// Operation
// - Frame of 1..8 falling edges resets device
// - Host ends init frame before ninth edge
// - Conversion completes within 2.94 us
// - Sampling lasts exactly 20 shift clocks
// - Three-state at edge 17 or select rise
// - Select fall drives result MSB
// - Frame-sync rise drives result MSB
// - Rising shift edge advances output bit
// - Host holds select past edge 16
// - Select high half period between frames
// - Select leads frame-sync; frame-sync pulse width
// - Init or cut conversion yields FF00
// - Output is previous frame's conversion
// - Conversion starts after falling edge 24
// - Sampling begins on fifth shift clock
`timescale 1ns/1ps
`include "sfc_defines.svh"
module sfc_device #(
  parameter int W          = `SFC_RESULT_W,
  parameter int CONV_CYCLES = `SFC_CONV_CYCLES
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  sfc_link_if.device        link,
  input  wire logic [W-1:0] analog_code_in,   // Digitised input value
  output logic              sampling_out,     // Sample phase active
  output logic              converting_out,   // Conversion running
  output logic              init_seen_out     // Last frame was a reset
);
  localparam logic [W-1:0] RST_CODE = W'(`SFC_RESET_CODE);
  sfc_pkg::sfc_dev_state_t st_reg, st_next;  // Frame state
  logic [5:0]   fall_reg, fall_next;   // Falling edges in frame
  logic [5:0]   rise_reg, rise_next;   // Rising edges in frame
  logic [W-1:0] shift_reg, shift_next; // Outgoing result
  logic [W-1:0] conv_reg, conv_next;   // Finished conversion
  logic [W-1:0] samp_reg, samp_next;   // Held sample
  logic [11:0]  ccnt_reg, ccnt_next;   // Conversion timer
  logic         oe_reg, oe_next;       // Output enable
  logic         cut_reg, cut_next;     // Force reset code next frame
  logic         samp_on_reg, samp_on_next;
  logic         init_reg, init_next;   // Last frame was a valid reset
  logic         conv_on_reg, conv_on_next; // Conversion running, registered
  logic         sclk_r;                // Shift clock rose
  logic         sclk_f;                // Shift clock fell
  logic         sel_r;                 // Select rose
  logic         sel_f;                 // Select fell
  logic         fs_r;                  // Frame-sync rose
  logic         active;                // Frame open, closing cycle included
  logic [2:0]   pins;                  // Frame-sync, select, shift clock
  logic [2:0]   pin_rise;              // Rising edge per pin
  logic [2:0]   pin_fall;              // Falling edge per pin
  // Host idle levels: select high, the others low. A detector reset to any
  // other level would report a false edge on the first cycle after reset.
  localparam logic [2:0] PIN_IDLE = 3'b010;

  assign pins = {link.frame_sync_input, link.sel_n, link.sclk};

  // One edge detector per link pin
  for (genvar i = 0; i < 3; i++) begin : g_edge
    sfc_edge_det #(
      .IDLE (PIN_IDLE[i])
    ) u_sfc_edge_det (
      .clk_in   (clk_in),
      .nrst_in  (nrst_in),
      .sig_in   (pins[i]),
      .rise_out (pin_rise[i]),
      .fall_out (pin_fall[i])
    );
  end

  // Named edges; a falling frame-sync edge needs no action here
  assign sclk_r = pin_rise[0];
  assign sclk_f = pin_fall[0];
  assign sel_r  = pin_rise[1];
  assign sel_f  = pin_fall[1];
  assign fs_r   = pin_rise[2];

  // Frame open while select and frame-sync are low. The host may release
  // select on the very clock that carries the last falling shift edge, so
  // the cycle in which either pin rises still counts as open.
  assign active = (~link.sel_n | sel_r) & (~link.frame_sync_input | fs_r);

  // Next-state logic for the whole frame engine
  always_comb begin
    st_next      = st_reg;
    fall_next    = fall_reg;
    rise_next    = rise_reg;
    shift_next   = shift_reg;
    conv_next    = conv_reg;
    samp_next    = samp_reg;
    ccnt_next    = ccnt_reg;
    oe_next      = oe_reg;
    cut_next     = cut_reg;
    samp_on_next = samp_on_reg;
    init_next    = init_reg;
    // Conversion timer runs on its own, no shift clock needed
    if (st_reg == sfc_pkg::SFC_CONV) begin
      if (ccnt_reg == 12'(CONV_CYCLES - 1)) begin
        conv_next = samp_reg;
        st_next   = sfc_pkg::SFC_IDLE;
      end else begin
        ccnt_next = ccnt_reg + 12'h001;
      end
    end
    // Frame start: load result and drive MSB
    if ((sel_f && !link.frame_sync_input) || (fs_r && !link.sel_n)) begin
      if (st_reg == sfc_pkg::SFC_CONV) begin
        cut_next = 1'b1;
        st_next  = sfc_pkg::SFC_IDLE;
      end
      shift_next = (cut_reg || init_reg || st_reg == sfc_pkg::SFC_CONV)
                   ? RST_CODE : conv_reg;
      oe_next    = 1'b1;
      fall_next  = 6'h00;
      rise_next  = 6'h00;
      // Cut and reset flags stay until the first falling shift edge: with
      // both pins in use the frame opens twice, at select fall and again
      // at frame-sync rise, and both openings must load the same word
    end
    if (active && st_reg != sfc_pkg::SFC_CONV) begin
      if (sclk_r) begin
        rise_next = rise_reg + 6'h01;
        // The MSB stands from frame opening through the first falling
        // edge, so the first rising edge leaves it in place
        if (rise_reg != 6'h00) begin
          shift_next = {shift_reg[W-2:0], 1'b0};
        end
        if (rise_reg == 6'(`SFC_TRISTATE_EDGE - 1)) begin
          oe_next = 1'b0;
        end
      end
      if (sclk_f) begin
        fall_next = fall_reg + 6'h01;
        // First falling edge: the word of this frame is committed
        if (fall_reg == 6'h00) begin
          cut_next  = 1'b0;
          init_next = 1'b0;
        end
        // The fifth shift period opens at the fourth falling edge; from
        // there to edge 24 is exactly twenty periods
        if (fall_reg == 6'(`SFC_SAMPLE_FIRST - 2)) begin
          samp_on_next = 1'b1;
          st_next      = sfc_pkg::SFC_SAMP;
        end
        if (fall_reg == 6'(`SFC_CONV_EDGE - 1)) begin
          samp_on_next = 1'b0;
          samp_next    = analog_code_in;
          st_next      = sfc_pkg::SFC_CONV;
          ccnt_next    = 12'h000;
        end
      end
    end
    // Select rising, or frame-sync rising with select high, ends the frame. The count includes a
    // falling edge seen in this same cycle, and a conversion that has
    // just been started keeps running.
    if (sel_r || (fs_r && link.sel_n)) begin
      oe_next      = 1'b0;
      samp_on_next = 1'b0;
      if (st_next != sfc_pkg::SFC_CONV) begin
        st_next = sfc_pkg::SFC_IDLE;
        if (fall_next >= 6'(`SFC_INIT_MIN_EDGE) &&
            fall_next <= 6'(`SFC_INIT_MAX_EDGE)) begin
          init_next = 1'b1;
        end else if (fall_next != 6'h00 &&
                     fall_next < 6'(`SFC_CONV_EDGE)) begin
          cut_next = 1'b1;
        end
      end
    end
    // Busy flag follows the state so the output comes from a flip-flop
    conv_on_next = (st_next == sfc_pkg::SFC_CONV);
  end

  // Register stage
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_reg      <= sfc_pkg::SFC_IDLE;
      fall_reg    <= 6'h00;
      rise_reg    <= 6'h00;
      shift_reg   <= '0;
      conv_reg    <= '0;
      samp_reg    <= '0;
      ccnt_reg    <= 12'h000;
      oe_reg      <= 1'b0;
      cut_reg     <= 1'b1;  // Power-on behaves as unconverted
      samp_on_reg <= 1'b0;
      init_reg    <= 1'b0;
      conv_on_reg <= 1'b0;
    end else begin
      st_reg      <= st_next;
      fall_reg    <= fall_next;
      rise_reg    <= rise_next;
      shift_reg   <= shift_next;
      conv_reg    <= conv_next;
      samp_reg    <= samp_next;
      ccnt_reg    <= ccnt_next;
      oe_reg      <= oe_next;
      cut_reg     <= cut_next;
      samp_on_reg <= samp_on_next;
      init_reg    <= init_next;
      conv_on_reg <= conv_on_next;
    end
  end

  assign link.sdo_o    = shift_reg[W-1];
  assign link.sdo_oe   = oe_reg;
  assign sampling_out  = samp_on_reg;
  assign converting_out = conv_on_reg;
  assign init_seen_out = init_reg;
endmodule

// ===== sfc_edge_det.sv
// Purpose: Edge detector on a synchronous pin; edges decoded from the pin against its registered last level
// Assumes: Input already synchronous to clk_in
// Notes:   Reset value chosen per pin idle level
`timescale 1ns/1ps
module sfc_edge_det #(
  parameter logic IDLE = 1'b0
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic sig_in,
  output logic      rise_out,
  output logic      fall_out
);
  logic prev_reg;  // Last sampled level
  logic prev_next;
  // Next value simply follows the pin
  always_comb begin
    prev_next = sig_in;
  end
  // Register the level
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      prev_reg <= IDLE;
    end else begin
      prev_reg <= prev_next;
    end
  end
  assign rise_out = sig_in & ~prev_reg;
  assign fall_out = ~sig_in & prev_reg;
endmodule

// ===== sfc_host.sv
// Purpose: Host end: generates shift clock and select, captures result
// Assumes: Shift clock derived from clk_in by a divider
// Notes:   Init frame uses INIT_EDGES falling edges
`timescale 1ns/1ps
`include "sfc_defines.svh"
module sfc_host #(
  parameter int W    = `SFC_RESULT_W,
  parameter int HALF = `SFC_SCLK_HALF,
  parameter int INIT_EDGES = 4,
  parameter int GAP  = 800
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  sfc_link_if.host          link,
  input  wire logic         start_in,    // Pulse: run a read frame
  input  wire logic         init_in,     // Pulse: run init frame
  input  wire logic         use_fs_in,   // Frame via frame-sync too
  output logic              busy_out,
  output logic              done_out,    // Pulse with data_out
  output logic [W-1:0]      data_out
);
  sfc_pkg::sfc_host_state_t st_reg, st_next;
  logic [11:0]  div_reg, div_next;     // Half-period / gap counter
  logic [5:0]   edge_reg, edge_next;   // Falling edges delivered
  logic [5:0]   last_reg, last_next;   // Edges for this frame
  logic [W-1:0] cap_reg, cap_next;
  logic [W-1:0] dat_reg, dat_next;
  logic         sclk_reg, sclk_next, sel_reg, sel_next, fs_reg, fs_next;
  logic         done_reg, done_next, fsm_reg, fsm_next;

  // Frame sequencer
  always_comb begin
    st_next = st_reg; div_next = div_reg; edge_next = edge_reg;
    last_next = last_reg; cap_next = cap_reg; dat_next = dat_reg;
    sclk_next = sclk_reg; sel_next = sel_reg; fs_next = fs_reg;
    done_next = 1'b0; fsm_next = fsm_reg;
    unique case (st_reg)
      sfc_pkg::SFC_H_IDLE: begin
        if (start_in || init_in) begin
          sel_next  = 1'b0;
          fsm_next  = use_fs_in;
          fs_next   = 1'b0;
          last_next = init_in ? 6'(INIT_EDGES) : 6'(`SFC_CONV_EDGE);
          edge_next = 6'h00; div_next = 12'h000; cap_next = '0;
          st_next   = sfc_pkg::SFC_H_SEL;
        end
      end
      sfc_pkg::SFC_H_SEL: begin  // Select leads frame-sync by a half
        div_next = div_reg + 12'h001;
        if (div_reg == 12'(HALF - 1)) begin
          div_next = 12'h000;
          fs_next  = fsm_reg;
          st_next  = fsm_reg ? sfc_pkg::SFC_H_FSHI : sfc_pkg::SFC_H_LOW;
        end
      end
      sfc_pkg::SFC_H_FSHI: begin // Frame-sync high a half period
        div_next = div_reg + 12'h001;
        if (div_reg == 12'(HALF - 1)) begin
          div_next = 12'h000; fs_next = 1'b0;
          st_next = sfc_pkg::SFC_H_LOW;
        end
      end
      sfc_pkg::SFC_H_LOW: begin
        div_next = div_reg + 12'h001;
        if (div_reg == 12'(HALF - 1)) begin
          div_next = 12'h000; sclk_next = 1'b1;
          st_next = sfc_pkg::SFC_H_HIGH;
        end
      end
      sfc_pkg::SFC_H_HIGH: begin
        div_next = div_reg + 12'h001;
        if (div_reg == 12'(HALF - 1)) begin
          div_next  = 12'h000; sclk_next = 1'b0;
          edge_next = edge_reg + 6'h01;
          if (edge_reg < 6'(W)) begin  // Capture on falling edge
            cap_next = {cap_reg[W-2:0], link.serial_result_out};
          end
          if (edge_reg + 6'h01 == last_reg) begin
            sel_next = 1'b1;  // Before ninth edge for init
            st_next  = sfc_pkg::SFC_H_GAP;
            if (last_reg != 6'(INIT_EDGES)) begin
              done_next = 1'b1; dat_next = cap_next;
            end
          end else begin
            st_next = sfc_pkg::SFC_H_LOW;
          end
        end
      end
      sfc_pkg::SFC_H_GAP: begin  // Select high; wait out conversion
        div_next = div_reg + 12'h001;
        if (div_reg == 12'(GAP - 1)) begin
          div_next = 12'h000; st_next = sfc_pkg::SFC_H_IDLE;
        end
      end
      default: st_next = sfc_pkg::SFC_H_IDLE;
    endcase
  end

  // Register stage
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_reg <= sfc_pkg::SFC_H_IDLE; div_reg <= 12'h000;
      edge_reg <= 6'h00; last_reg <= 6'h00; cap_reg <= '0;
      dat_reg <= '0; sclk_reg <= 1'b0; sel_reg <= 1'b1;
      fs_reg <= 1'b0; done_reg <= 1'b0; fsm_reg <= 1'b0;
    end else begin
      st_reg <= st_next; div_reg <= div_next; edge_reg <= edge_next;
      last_reg <= last_next; cap_reg <= cap_next; dat_reg <= dat_next;
      sclk_reg <= sclk_next; sel_reg <= sel_next; fs_reg <= fs_next;
      done_reg <= done_next; fsm_reg <= fsm_next;
    end
  end

  assign link.sclk             = sclk_reg;
  assign link.sel_n            = sel_reg;
  assign link.frame_sync_input = fs_reg;
  assign busy_out = (st_reg != sfc_pkg::SFC_H_IDLE);
  assign done_out = done_reg;
  assign data_out = dat_reg;
endmodule

// ===== sfc_link_if.sv
// Purpose: Serial link between converter host and converter device
// Assumes: Pins sampled on clk_in; result pin is three-state
// Notes:   Wire level of the result pin resolved here from its enable
`timescale 1ns/1ps
interface sfc_link_if;
  logic sclk;              // Shift clock from host
  logic sel_n;             // Active-low select from host
  logic frame_sync_input;  // Frame sync from host
  logic sdo_o;             // Result bit driven by device
  logic sdo_oe;            // High while device drives the pin
  logic serial_result_out; // Resolved pin level, high when floating
  assign serial_result_out = sdo_oe ? sdo_o : 1'b1;
  modport device (input sclk, sel_n, frame_sync_input,
                  output sdo_o, sdo_oe);
  modport host (output sclk, sel_n, frame_sync_input,
                input serial_result_out);
endinterface

// ===== sfc_link_monitor.sv
// Purpose: Assertions on the converter link pins
// Assumes: Pins synchronous to clk_in; one clock domain
// Notes:   Shift edge counts restart at every frame opening
`timescale 1ns/1ps
module sfc_link_monitor (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic frame_sync_input,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic serial_result_out
);
  logic       sclk_reg;            // Last shift clock level
  logic       sel_reg;             // Last select level
  logic       fs_reg;              // Last frame-sync level
  logic       s_up;                // Shift clock rose
  logic [5:0] rise_reg, rise_next; // Rising shift edges this frame
  logic [5:0] fall_reg, fall_next; // Falling shift edges this frame
  // Edge counts; a select fall or frame-sync fall opens a frame
  always_comb begin
    s_up      = sclk & ~sclk_reg;
    rise_next = rise_reg + {5'h0, s_up};
    fall_next = fall_reg + {5'h0, ~sclk & sclk_reg};
    if ((sel_reg & ~sel_n) | (fs_reg & ~frame_sync_input)) begin
      rise_next = 6'h0;
      fall_next = 6'h0;
    end
  end
  // Registers only; idle levels chosen to match the host after reset
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sclk_reg <= 1'b0;
      sel_reg  <= 1'b1;
      fs_reg   <= 1'b0;
      rise_reg <= 6'h0;
      fall_reg <= 6'h0;
    end else begin
      sclk_reg <= sclk;
      sel_reg  <= sel_n;
      fs_reg   <= frame_sync_input;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Device lets go of the pin within two cycles
  sequence released_s;
    ##[1:2] !sdo_oe;
  endsequence
  // Frame-sync held for half a shift period
  sequence fs_held_s;
    frame_sync_input [*4];
  endsequence
  oe_on_select_a: assert property ($fell(sel_n) |-> ##1 sdo_oe)
    else $error("result pin not driven after select fall");
  oe_on_sync_a: assert property (
    $rose(frame_sync_input) && !sel_n |-> ##[1:2] sdo_oe)
    else $error("result pin not driven after frame-sync rise");
  tri_17th_a: assert property (s_up && rise_reg == 6'd16 |-> released_s)
    else $error("result pin still driven after edge 17");
  tri_select_a: assert property ($rose(sel_n) |-> released_s)
    else $error("result pin still driven after select rise");
  // Bit may only move shortly after a rising shift edge
  bit_hold_a: assert property (
    sdo_oe && $past(sdo_oe) && !sclk && !$past(sclk) && !$past(sclk, 2)
    && $stable(sel_n) && $stable(frame_sync_input)
    && frame_sync_input == $past(frame_sync_input, 2)
    |-> $stable(serial_result_out) && serial_result_out == sdo_o)
    else $error("result bit moved while shift clock low");
  sel_gap_a: assert property ($rose(sel_n) |-> sel_n [*4])
    else $error("select high too briefly");
  // Count taken with the falling edge that may share select's release
  sel_hold_a: assert property ($rose(sel_n) |->
    fall_next inside {[6'd1:6'd8]} || fall_next >= 6'd16)
    else $error("select released at a wrong edge count");
  fs_pulse_a: assert property ($rose(frame_sync_input) |->
    (!sel_n && !$past(sel_n, 4)) ##0 fs_held_s)
    else $error("frame-sync setup or width too short");
endmodule

// ===== sfc_pkg.sv
// Purpose: Types shared by both ends of the converter link
// Assumes: Constants live in sfc_defines.svh
// Notes:   No imports; use sfc_pkg::name
package sfc_pkg;
  // Device frame states, Gray coded in listed order; the device steps only IDLE, SAMP, CONV
  typedef enum logic [2:0] {
    SFC_IDLE  = 3'b000,
    SFC_SHIFT = 3'b001,
    SFC_SAMP  = 3'b011,
    SFC_WAIT  = 3'b010,
    SFC_CONV  = 3'b110
  } sfc_dev_state_t;
  // Host states
  typedef enum logic [2:0] {
    SFC_H_IDLE = 3'b000,
    SFC_H_SEL  = 3'b001,
    SFC_H_FSHI = 3'b011,
    SFC_H_LOW  = 3'b010,
    SFC_H_HIGH = 3'b110,
    SFC_H_GAP  = 3'b111
  } sfc_host_state_t;
endpackage
